// *** rtl/fsis_consts.svh ***
// fsis_consts.svh: step sizes, codes and timing counts for the flash start-up sequencer
// assumes a 250 MHz system clock; included by bare name
`ifndef FSIS_CONSTS_SVH
`define FSIS_CONSTS_SVH

// clock period in picoseconds
`define FSIS_CLK_PS 4000
// led ramp timing in nanoseconds
`define FSIS_RISE_DD_NS 12000
`define FSIS_RISE_HC_NS 500
`define FSIS_FALL_NS 500
// number of ramp steps across full scale (code width 4 bits)
`define FSIS_CODE_STEPS 15
// ramp tick intervals, longest time rounded down; the sequencer clamps the hc and fall ticks to at least one cycle
`define FSIS_TICK_DD ((`FSIS_RISE_DD_NS * 1000 / `FSIS_CLK_PS) / `FSIS_CODE_STEPS)
`define FSIS_TICK_HC ((`FSIS_RISE_HC_NS * 1000 / `FSIS_CLK_PS) / `FSIS_CODE_STEPS)
`define FSIS_TICK_FALL ((`FSIS_FALL_NS * 1000 / `FSIS_CLK_PS) / `FSIS_CODE_STEPS)
// first limit step duration: 1 ms
`define FSIS_STEP1_US 1000
`define FSIS_STEP1_CYC (`FSIS_STEP1_US * 1000000 / `FSIS_CLK_PS)
// led step sizes in microamps, and the high-current ratio as 9/4
`define FSIS_STEP_DD_UA 27500
`define FSIS_STEP_HC_UA 62000
`define FSIS_HC_NUM 9
`define FSIS_HC_DEN 4
// valley limit codes in milliamps; zero means power stage off
`define FSIS_VALLEY_LIMIT_SELECT_OFF 11'h000
`define FSIS_VALLEY_LIMIT_SELECT_30 11'h01e
`define FSIS_VALLEY_LIMIT_SELECT_250 11'h0fa
`define FSIS_VALLEY_LIMIT_SELECT_1150 11'h47e
`define FSIS_VALLEY_LIMIT_SELECT_1600 11'h640
// mode field codes
`define FSIS_MODE_SHDN 2'h0
`define FSIS_MODE_DCL 2'h1
`define FSIS_MODE_FLASH 2'h2

`endif

// *** rtl/fsis_pkg.sv ***
// fsis_pkg.sv: types for the flash start-up sequencer
// assumes nothing from fsis_consts.svh; the state codes are set here
package fsis_pkg;
  // gray-coded start-up phases along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRECHG = 3'h1,
    ST_STEP1 = 3'h3,
    ST_STEP2 = 3'h2,
    ST_FULL = 3'h6
  } fsis_state_type;
endpackage

// *** rtl/fsis_sequencer.sv ***
// fsis_sequencer.sv: start-up, valley limit and led ramp control of a flash boost stage
// assumes analog comparators arrive asynchronously; comparator, select and mask levels are synchronised here, mode, strobe, target and led enables are not
`timescale 1ns/1ps
`include "fsis_consts.svh"

module fsis_sequencer
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_mode,
  input wire logic i_voltage_mode_enable,
  input wire logic i_valley_limit_select,
  input wire logic i_high_current_select,
  input wire logic i_tx_mask,
  input wire logic i_near_vin,
  input wire logic i_above_3v3,
  input wire logic i_in_regulation,
  input wire logic i_down_mode,
  input wire logic i_valley_over,
  input wire logic i_off_time_done,
  input wire logic [3:0] i_led_target,
  input wire logic [2:0] i_led_input_enables,
  input wire logic [15:0] i_safety_ticks,
  input wire logic i_strobe,
  output logic o_rectifier_on,
  output logic o_switching,
  output logic o_on_time_start,
  output logic [10:0] o_valley_limit_ma,
  output logic o_power_stage_off,
  output logic o_balance_enable,
  output logic [3:0] o_led_code,
  output logic [2:0] o_led_sink_enable,
  output logic [19:0] o_led_current_ua,
  output logic o_safety_expired,
  output logic o_busy
);

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign async_in = {i_voltage_mode_enable, i_valley_limit_select, i_high_current_select,
                     i_tx_mask, i_near_vin, i_above_3v3, i_in_regulation, i_down_mode,
                     i_valley_over, i_off_time_done};

  // two flops per pin level; first stage only feeds the second
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  logic vm_en, valley_limit_select_pin, high_current_select, tx_mask, near_vin, above_3v3, in_reg, down_mode;
  logic valley_over, off_done;
  assign {vm_en, valley_limit_select_pin, high_current_select, tx_mask, near_vin, above_3v3, in_reg, down_mode,
          valley_over, off_done} = sync2_q;

  logic shutdown;
  assign shutdown = (i_mode == `FSIS_MODE_SHDN);

  // ==========================================================
  // limit select latch
  // ==========================================================
  logic valley_limit_select_q;
  // writes are ignored once operation starts
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      valley_limit_select_q <= 1'b0;
    else if (shutdown)
      valley_limit_select_q <= valley_limit_select_pin;
  end

  // ==========================================================
  // start-up state machine
  // ==========================================================
  fsis_pkg::fsis_state_type state_q;
  logic [17:0] step1_cnt_q;
  logic prechg_done;
  logic current_only;
  assign current_only = ((i_mode == `FSIS_MODE_DCL) || (i_mode == `FSIS_MODE_FLASH)) && !vm_en;
  // hc current-only mode waits for vin only; else whichever comes first
  assign prechg_done = (high_current_select && current_only) ? near_vin : (near_vin || above_3v3);

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_q <= fsis_pkg::ST_IDLE;
    else if (shutdown)
      state_q <= fsis_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        fsis_pkg::ST_IDLE:
          state_q <= fsis_pkg::ST_PRECHG;
        fsis_pkg::ST_PRECHG:
          // mask holds the phase in high-current mode
          if (prechg_done && !(high_current_select && tx_mask))
            state_q <= high_current_select ? fsis_pkg::ST_STEP2 : fsis_pkg::ST_STEP1;
        fsis_pkg::ST_STEP1:
          if (step1_cnt_q == 18'(`FSIS_STEP1_CYC - 1))
            state_q <= fsis_pkg::ST_STEP2;
        fsis_pkg::ST_STEP2:
          // direct mode waits for regulation, hc for boost operation
          if (high_current_select ? !down_mode : in_reg)
            state_q <= fsis_pkg::ST_FULL;
        fsis_pkg::ST_FULL:
          state_q <= fsis_pkg::ST_FULL;
        default:
          state_q <= fsis_pkg::ST_IDLE;
      endcase
    end
  end

  // one millisecond of operation at the first step
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      step1_cnt_q <= '0;
    else if (state_q == fsis_pkg::ST_STEP1)
      step1_cnt_q <= step1_cnt_q + 18'h00001;
    else
      step1_cnt_q <= '0;
  end

  // ==========================================================
  // valley limit selection
  // ==========================================================
  function automatic logic [10:0] full_limit(input logic sel);
    full_limit = sel ? `FSIS_VALLEY_LIMIT_SELECT_1600 : `FSIS_VALLEY_LIMIT_SELECT_1150;
  endfunction
  function automatic logic [10:0] low_limit(input logic sel);
    low_limit = sel ? `FSIS_VALLEY_LIMIT_SELECT_250 : `FSIS_VALLEY_LIMIT_SELECT_30;
  endfunction

  logic [10:0] limit_d;
  logic stage_off;
  assign stage_off = high_current_select && tx_mask;
  always_comb
  begin
    limit_d = full_limit(valley_limit_select_q);
    if (high_current_select)
      limit_d = stage_off ? `FSIS_VALLEY_LIMIT_SELECT_OFF : low_limit(valley_limit_select_q);
    if (state_q == fsis_pkg::ST_STEP1)
      limit_d = `FSIS_VALLEY_LIMIT_SELECT_30;
    else if (state_q == fsis_pkg::ST_STEP2)
      limit_d = high_current_select ? low_limit(valley_limit_select_q) : `FSIS_VALLEY_LIMIT_SELECT_250;
    if (stage_off)
      limit_d = `FSIS_VALLEY_LIMIT_SELECT_OFF;
  end

  // registered power-stage controls
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_valley_limit_ma <= `FSIS_VALLEY_LIMIT_SELECT_OFF;
      o_power_stage_off <= 1'b1;
      o_rectifier_on <= 1'b0;
      o_switching <= 1'b0;
      o_balance_enable <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_valley_limit_ma <= shutdown ? `FSIS_VALLEY_LIMIT_SELECT_OFF : limit_d;
      o_power_stage_off <= shutdown || stage_off;
      o_rectifier_on <= (state_q == fsis_pkg::ST_PRECHG) && !stage_off;
      o_switching <= !stage_off && (state_q == fsis_pkg::ST_STEP1 ||
                     state_q == fsis_pkg::ST_STEP2 || state_q == fsis_pkg::ST_FULL);
      o_balance_enable <= high_current_select && !shutdown;
      o_busy <= (state_q != fsis_pkg::ST_FULL) && !shutdown;
    end
  end

  // ==========================================================
  // off-time extension
  // ==========================================================
  // next on-time waits while the valley current is still above the limit
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_on_time_start <= 1'b0;
    else
      o_on_time_start <= o_switching && off_done && !valley_over && !o_on_time_start;
  end

  // ==========================================================
  // led current ramp
  // ==========================================================
  localparam logic [7:0] TICK_DD = 8'(`FSIS_TICK_DD);
  localparam logic [7:0] TICK_HC = 8'(((`FSIS_TICK_HC) < 1) ? 1 : `FSIS_TICK_HC);
  localparam logic [7:0] TICK_FALL = 8'(((`FSIS_TICK_FALL) < 1) ? 1 : `FSIS_TICK_FALL);
  logic [7:0] tick_cnt_q;
  logic [7:0] tick_len;
  logic [3:0] target;
  logic going_up;
  logic tick;
  assign target = (shutdown || !i_strobe) ? 4'h0 : i_led_target;
  assign going_up = target > o_led_code;
  // fall is fast in both modes; rise speed depends on mode
  assign tick_len = going_up ? (high_current_select ? TICK_HC : TICK_DD) : TICK_FALL;
  assign tick = (tick_cnt_q >= tick_len - 8'h01);

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      tick_cnt_q <= '0;
    else if (target == o_led_code || tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 8'h01;
  end

  // one code step per tick toward the target
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_led_code <= 4'h0;
    else if (tick && going_up)
      o_led_code <= o_led_code + 4'h1;
    else if (tick && target < o_led_code)
      o_led_code <= o_led_code - 4'h1;
  end

  // current in microamps; hc step is the direct step scaled by 9/4
  // full scale in hc mode needs 20 bits, so the port is sized for it
  logic [19:0] cur_dd;
  assign cur_dd = 20'(o_led_code) * 20'(`FSIS_STEP_DD_UA);
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_led_current_ua <= '0;
    else
      o_led_current_ua <= high_current_select ? 20'((cur_dd * `FSIS_HC_NUM) / `FSIS_HC_DEN) : cur_dd;
  end

  // sink enables follow the inputs one cycle later, cleared in shutdown; paralleling needs no special handling
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_led_sink_enable <= 3'h0;
    else
      o_led_sink_enable <= shutdown ? 3'h0 : i_led_input_enables;
  end

  // ==========================================================
  // safety timer
  // ==========================================================
  // counts oscillator cycles, so its length tracks oscillator accuracy
  logic [15:0] safety_cnt_q;
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      safety_cnt_q <= '0;
      o_safety_expired <= 1'b0;
    end
    else if (!i_strobe || shutdown)
    begin
      safety_cnt_q <= '0;
      o_safety_expired <= 1'b0;
    end
    else if (safety_cnt_q >= i_safety_ticks)
      o_safety_expired <= 1'b1;
    else
      safety_cnt_q <= safety_cnt_q + 16'h0001;
  end

  // ==========================================================
  // checks
  // ==========================================================
  stage_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (high_current_select && tx_mask) |=> o_power_stage_off && o_valley_limit_ma == 11'h000)
    else $error("power stage not off under mask");
  shutdown_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_mode == 2'h0) |=> state_q == fsis_pkg::ST_IDLE)
    else $error("sequencer not idle in shutdown");
  balance_mode_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!high_current_select) |=> !o_balance_enable)
    else $error("balancing on in direct mode");
  balance_hc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (high_current_select && i_mode != 2'h0) |=> o_balance_enable)
    else $error("balancing off in high-current mode");
  limit_latch_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_mode != 2'h0) |=> $stable(valley_limit_select_q))
    else $error("limit select changed while running");
  full_limit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q == fsis_pkg::ST_FULL && !high_current_select && i_mode != 2'h0 && $stable(state_q))
    |=> o_valley_limit_ma == (valley_limit_select_q ? 11'h640 : 11'h47e))
    else $error("wrong full limit in direct mode");
  step1_limit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q == fsis_pkg::ST_STEP1 && !stage_off && i_mode != 2'h0)
    |=> o_valley_limit_ma == 11'h01e)
    else $error("first step limit wrong");
  mask_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_q == fsis_pkg::ST_PRECHG && high_current_select && tx_mask && i_mode != 2'h0)
    |=> state_q == fsis_pkg::ST_PRECHG)
    else $error("precharge left under mask");
  rect_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rectifier_on |-> !o_switching)
    else $error("switching during precharge");
  ramp_step_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_led_code != $past(o_led_code) |-> (o_led_code - $past(o_led_code) == 4'h1) ||
    ($past(o_led_code) - o_led_code == 4'h1))
    else $error("ramp moved more than one step");
  on_time_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    valley_over |=> !o_on_time_start)
    else $error("on-time started above limit");

endmodule // fsis_sequencer

// *** verif/fsis_stage_model.sv ***
// fsis_stage_model.sv: behavioural power stage, storage capacitor and comparators
// assumes the sequencer's stage controls as inputs; one clock, async reset
`timescale 1ns/1ps

module fsis_stage_model
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_rectifier_on,
  input wire logic i_switching,
  input wire logic i_on_time_start,
  input wire logic i_vin_high,
  input wire logic i_overload,
  input wire logic i_discharge,
  output logic o_near_vin,
  output logic o_above_3v3,
  output logic o_in_regulation,
  output logic o_down_mode,
  output logic o_valley_over,
  output logic o_off_time_done
);
  logic [6:0] chg_q;
  logic [5:0] sw_q;
  logic [2:0] off_q;
  // ==========================================================
  // capacitor charge: rises only while the rectifier conducts, holds when suspended
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      chg_q <= 7'h00;
    else if (i_discharge)
      chg_q <= 7'h00;
    else if (i_rectifier_on && chg_q != 7'h7f)
      chg_q <= chg_q + 7'h01;
  end
  // switching age: regulation and boost entry come 30 cycles after start
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      sw_q <= 6'h00;
    else if (!i_switching)
      sw_q <= 6'h00;
    else if (sw_q != 6'h3f)
      sw_q <= sw_q + 6'h01;
  end
  // off-time age since the last on-time
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      off_q <= 3'h0;
    else if (i_on_time_start)
      off_q <= 3'h0;
    else if (off_q != 3'h7)
      off_q <= off_q + 3'h1;
  end
  // a high battery reaches 3.3 V well before the output gets near it
  assign o_near_vin = (chg_q >= 7'h3c);
  assign o_above_3v3 = i_vin_high && (chg_q >= 7'h14);
  assign o_in_regulation = (sw_q >= 6'h1e);
  assign o_down_mode = i_switching && (sw_q < 6'h1e);
  assign o_valley_over = i_overload;
  assign o_off_time_done = (off_q >= 3'h3);
endmodule // fsis_stage_model

// *** verif/fsis_sequencer_bench.sv ***
// fsis_sequencer_bench.sv: self-checking bench of the start-up sequencer
// assumes fsis_stage_model on the stage side; inputs change 1 ns after the edge
`timescale 1ns/1ps

module fsis_sequencer_bench;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, vmode = 1'b0, sel = 1'b1, hc = 1'b0, mask = 1'b0;
  logic strobe = 1'b0, vin_high = 1'b1, overload = 1'b0, discharge = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [3:0] target = 4'h0;
  logic [2:0] en = 3'h5;
  logic [15:0] ticks = 16'h012c;
  logic near, a33, inreg, down, vover, offd, rect, sw, ots, pso, bal, expd, busy;
  logic [10:0] lim;
  logic [3:0] code;
  logic [2:0] sink;
  logic [19:0] cur;
  logic [3:0] cnd;
  int errors = 0, n_tests = 0, n;

  fsis_sequencer dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mode(mode),
    .i_voltage_mode_enable(vmode), .i_valley_limit_select(sel), .i_high_current_select(hc),
    .i_tx_mask(mask), .i_near_vin(near), .i_above_3v3(a33), .i_in_regulation(inreg),
    .i_down_mode(down), .i_valley_over(vover), .i_off_time_done(offd), .i_led_target(target),
    .i_led_input_enables(en), .i_safety_ticks(ticks), .i_strobe(strobe),
    .o_rectifier_on(rect), .o_switching(sw), .o_on_time_start(ots), .o_valley_limit_ma(lim),
    .o_power_stage_off(pso), .o_balance_enable(bal), .o_led_code(code),
    .o_led_sink_enable(sink), .o_led_current_ua(cur), .o_safety_expired(expd), .o_busy(busy));
  fsis_stage_model stage (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rectifier_on(rect),
    .i_switching(sw), .i_on_time_start(ots), .i_vin_high(vin_high), .i_overload(overload),
    .i_discharge(discharge), .o_near_vin(near), .o_above_3v3(a33), .o_in_regulation(inreg),
    .o_down_mode(down), .o_valley_over(vover), .o_off_time_done(offd));

  // ==========================================================
  // clock and shared tasks
  always #2 i_clk = ~i_clk;
  assign cnd = {ots, expd, ~busy, sw};

  task tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  // bounded wait on one watched output; running out ends the run
  task wait_for(input int s, input int max);
    n = 0;
    while (cnd[s] !== 1'b1 && n < max)
    begin
      tick(1);
      n++;
    end
    check(n < max, "wait ran out");
    if (n >= max)
      wrap_up;
  endtask
  // the first code change may be partial, so the second interval is timed
  task step_time(input int exp);
    logic [3:0] c0;
    int k;
    repeat (2)
    begin
      c0 = code;
      k = 0;
      while (code === c0 && k < 400)
      begin
        tick(1);
        k++;
      end
    end
    check(k >= exp - 1 && k <= exp + 1, "ramp tick length");
    if (k >= 400)
      wrap_up;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    tick(2);
    check(pso === 1'b1 && sw === 1'b0 && busy === 1'b0 && sink === 3'h0, "reset");
    i_sys_rst = 1'b0;
    tick(4);
    discharge = 1'b0; // only the connected inputs are enabled
    mode = 2'h1;
    tick(6);
    check(rect === 1'b1 && sw === 1'b0, "precharge first");
    wait_for(0, 40);
    tick(3);
    check(lim === 11'h01e && bal === 1'b0 && sink === 3'h5, "direct step one");
    tick(1000);
    check(lim === 11'h01e && busy === 1'b1, "step one holds");
    mode = 2'h0;
    discharge = 1'b1;
    tick(8);
    check(busy === 1'b0 && sw === 1'b0 && sink === 3'h0, "shutdown idle");
    $display("test direct start-up done");
    hc = 1'b1;
    mask = 1'b1;
    discharge = 1'b0;
    mode = 2'h1;
    tick(100);
    check(sw === 1'b0 && rect === 1'b0 && pso === 1'b1, "mask suspends");
    mask = 1'b0;
    tick(45);
    check(sw === 1'b0, "current-only waits for near input");
    wait_for(0, 60);
    tick(3);
    check(lim === 11'h0fa && bal === 1'b1, "hc down-mode limit");
    wait_for(1, 60);
    sel = 1'b0;
    tick(8);
    check(lim === 11'h0fa, "select ignored outside shutdown");
    overload = 1'b1;
    tick(6);
    n = 0;
    repeat (40)
    begin
      tick(1);
      if (ots === 1'b1)
        n++;
    end
    check(n == 0, "off-time extended");
    overload = 1'b0;
    wait_for(3, 30);
    $display("test high-current start-up done");
    target = 4'h2;
    strobe = 1'b1;
    step_time(8);
    tick(4);
    check(code === 4'h2 && cur === 20'h1e366, "hc current");
    target = 4'h0;
    step_time(8);
    wait_for(2, 320);
    check(n > 240, "safety timer length");
    strobe = 1'b0;
    tick(4);
    check(expd === 1'b0, "expiry clears");
    $display("test hc ramp done");
    hc = 1'b0;
    ticks = 16'hffff;
    tick(8);
    check(lim === 11'h640 && bal === 1'b0, "direct full limit");
    target = 4'h2;
    strobe = 1'b1;
    step_time(200);
    tick(210);
    check(cur === 20'h0d6d8, "direct current");
    target = 4'h0;
    step_time(8);
    hc = 1'b1;
    mask = 1'b1;
    tick(8);
    check(pso === 1'b1 && lim === 11'h000 && sw === 1'b0, "stage off");
    mask = 1'b0;
    tick(8);
    check(pso === 1'b0, "stage back on");
    $display("test direct ramp and mask done");
    // restart in hc mode with the low select latched during shutdown
    mode = 2'h0;
    discharge = 1'b1;
    tick(8);
    check(lim === 11'h000 && pso === 1'b1, "shutdown stage off");
    discharge = 1'b0;
    mode = 2'h1;
    tick(4);
    check(rect === 1'b1 && busy === 1'b1, "restart from precharge");
    wait_for(1, 150);
    tick(2);
    check(lim === 11'h01e && sink === 3'h5, "hc low limit latched");
    hc = 1'b0;
    tick(8);
    check(lim === 11'h47e, "direct low full limit");
    $display("test restart with low limit done");
    wrap_up;
  end
endmodule // fsis_sequencer_bench
